//--- common/pause_fc_pkg.sv
// Purpose: shared constants of the mac pause flow control block
// Assumes: 100 MHz mac clock, byte-wide frame streams
// Notes:   register map, field layout and frame timing live here
package pause_fc_pkg;

   // register map (printed offsets, plain register port)
   localparam logic [7:0]  FLOW_OFFSET       = 8'h08;
   localparam logic [31:0] FLOW_RESET        = 32'h0000_0000;

   // pause_flow_control field positions
   localparam int          PAUSE_TIME_LSB    = 16;
   localparam int          PASS_CTRL_BIT     = 2;
   localparam int          FLOW_EN_BIT       = 1;
   localparam int          BUSY_BIT          = 0;

   // pause frame layout: 60 bytes before the appended fcs
   localparam logic [5:0]  FRAME_LAST_IDX    = 6'h3b;
   localparam logic [5:0]  SRC_ADDR_IDX      = 6'h06;
   localparam logic [5:0]  TYPE_IDX          = 6'h0c;
   localparam logic [5:0]  OPCODE_IDX        = 6'h0e;
   localparam logic [5:0]  PTIME_IDX         = 6'h10;
   localparam logic [5:0]  PAD_IDX           = 6'h12;
   localparam logic [47:0] PAUSE_DEST_ADDR   = 48'h0180_c200_0001;
   localparam logic [15:0] CTRL_ETHERTYPE    = 16'h8808;
   localparam logic [15:0] PAUSE_OPCODE      = 16'h0001;

   // slot time = 512 bit times, counted in mac clocks
   localparam int          CLK_PERIOD_PS     = 10000;
   localparam int          SLOT_BITS         = 512;
   localparam int          BIT_PS_100M       = 10000;
   localparam int          BIT_PS_10M        = 100000;
   localparam int          SLOT_CYCLES_100M  =
      (SLOT_BITS * BIT_PS_100M) / CLK_PERIOD_PS;
   localparam int          SLOT_CYCLES_10M   =
      (SLOT_BITS * BIT_PS_10M) / CLK_PERIOD_PS;
   localparam int          SLOT_CNT_W        = 13;

   // transmit sequencer states
   typedef enum logic [0:0] {
      TX_IDLE,
      TX_SEND
   } tx_state_t;

endpackage : pause_fc_pkg

//--- common/pause_frame_if.sv
// Purpose: link between the flow control core and its frame byte source
// Assumes: one byte of latency from index to data
// Notes:   data for idx appear on the clock edge after idx is applied
interface pause_frame_if;
   logic [5:0]  idx;
   logic [47:0] src_addr;
   logic [15:0] pause_time;
   logic [7:0]  data;

   modport builder (
      input  idx,
      input  src_addr,
      input  pause_time,
      output data
   );

   modport user (
      output idx,
      output src_addr,
      output pause_time,
      input  data
   );
endinterface : pause_frame_if

//--- design/mac_pause_flow_control.sv
// Purpose: pause frame send, pause receive and back pressure of the mac
// Assumes: all inputs come from mac logic on i_mclk, no synchronisers
// Notes:   one register, pause_flow_control, on the plain register port
//
// Operation
// - sent pause frames carry the standard control frame fields.
// - the pause time field of a sent frame is register bits 31-16.
// - in full duplex busy stays high from frame start until the cable reports the frame sent.
// - in half duplex busy is high while back pressure is asserted.
// - a valid pause frame's filter status follows pass control frames.
// - every received frame's data is forwarded whatever the settings.
// - an active filtering mode decides the filter status over pass.
// - with flow on in full duplex a pause stalls tx for time x slots.
// - with flow off no frames are decoded and no pause is applied.
// - in half duplex flow enable turns on back pressure.
// - no pause frame starts and no back pressure while tx is disabled; a frame already started is sent to its end.
//
// Strobed register access was decided locally.
module mac_pause_flow_control
   import pause_fc_pkg::*;
#(
   parameter logic [SLOT_CNT_W-1:0] SLOT_CYCLES_10 =
      SLOT_CNT_W'(SLOT_CYCLES_10M)
)(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // register port
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [31:0] o_reg_rdata,
   // mac mode
   input  wire logic        i_full_duplex,
   input  wire logic        i_speed_100,
   input  wire logic        i_tx_enable,
   input  wire logic [47:0] i_station_addr,
   // flow requests from the receive buffer side
   input  wire logic        i_pause_req,
   input  wire logic        i_rx_congested,
   // pause frame stream to the transmitter
   output logic      [7:0]  o_tx_data,
   output logic             o_tx_valid,
   output logic             o_tx_last,
   input  wire logic        i_tx_ready,
   input  wire logic        i_tx_done,
   // transmitter stall and back pressure
   output logic             o_tx_pause,
   output logic             o_back_pressure,
   // received frame stream from the mac
   input  wire logic [7:0]  i_rxd,
   input  wire logic        i_rx_valid,
   input  wire logic        i_rx_sof,
   input  wire logic        i_rx_eof,
   input  wire logic        i_rx_good,
   input  wire logic        i_filter_pass,
   input  wire logic        i_filter_mode_active,
   // received frame stream to the application
   output logic      [7:0]  o_rxd,
   output logic             o_rx_valid,
   output logic             o_rx_sof,
   output logic             o_rx_eof,
   output logic             o_rx_status_valid,
   output logic             o_rx_filter
);

   // ---------------- register port ----------------
   logic [15:0] pause_time_reg;
   logic        pass_ctrl_reg;
   logic        flow_en_reg;
   logic        busy;
   logic        flow_sel;
   logic        flow_wr;
   logic [31:0] flow_read;
   logic [31:0] rdata_next;

   // address decode and read mux
   assign flow_sel   = (i_reg_addr == FLOW_OFFSET);
   assign flow_wr    = i_reg_wr && flow_sel;
   assign flow_read  = {pause_time_reg, 13'h0000, pass_ctrl_reg,
                        flow_en_reg, busy};
   assign rdata_next = (i_reg_rd && flow_sel) ? flow_read : 32'h0000_0000;

   // control fields; the busy position of the write data is dropped
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         pause_time_reg <= FLOW_RESET[31:16];
         pass_ctrl_reg  <= FLOW_RESET[PASS_CTRL_BIT];
         flow_en_reg    <= FLOW_RESET[FLOW_EN_BIT];
      end else if (flow_wr) begin
         pause_time_reg <= i_reg_wdata[31:PAUSE_TIME_LSB];
         pass_ctrl_reg  <= i_reg_wdata[PASS_CTRL_BIT];
         flow_en_reg    <= i_reg_wdata[FLOW_EN_BIT];
      end
   end

   // read data, valid only in the cycle after the read strobe
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_reg_rdata <= 32'h0000_0000;
      end else begin
         o_reg_rdata <= rdata_next;
      end
   end

   // ---------------- pause frame transmit ----------------
   tx_state_t   tx_state_reg;
   tx_state_t   tx_state_next;
   logic [5:0]  tx_idx_reg;
   logic [5:0]  tx_idx_next;
   logic        tx_start;
   logic        tx_step;
   logic        tx_end;
   logic        tx_valid_next;
   logic        tx_last_next;
   logic        wait_done_reg;
   logic        fd_busy_reg;

   pause_frame_if frm ();

   // frame byte source; byte for tx_idx_next lands with tx_idx_reg
   assign frm.idx        = tx_idx_next;
   assign frm.src_addr   = i_station_addr;
   assign frm.pause_time = pause_time_reg;

   pause_frame_rom u_rom (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .frm     (frm)
   );

   // start only in full duplex with the transmitter on and not busy
   assign tx_start = (tx_state_reg == TX_IDLE) && !fd_busy_reg &&
                     i_pause_req && i_full_duplex && i_tx_enable;
   assign tx_step  = (tx_state_reg == TX_SEND) && i_tx_ready;
   assign tx_end   = tx_step && (tx_idx_reg == FRAME_LAST_IDX);

   // sequencer next state
   always_comb begin
      tx_state_next = tx_state_reg;
      tx_idx_next   = tx_idx_reg;
      tx_valid_next = 1'b0;
      tx_last_next  = 1'b0;
      unique case (tx_state_reg)
         TX_IDLE: begin
            if (tx_start) begin
               tx_state_next = TX_SEND;
               tx_idx_next   = 6'h00;
               tx_valid_next = 1'b1;
            end
         end
         TX_SEND: begin
            tx_valid_next = 1'b1;
            if (tx_end) begin
               tx_state_next = TX_IDLE;
               tx_valid_next = 1'b0;
            end else if (tx_step) begin
               tx_idx_next = tx_idx_reg + 6'h01;
            end
            tx_last_next = tx_valid_next &&
                           (tx_idx_next == FRAME_LAST_IDX);
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         tx_state_reg <= TX_IDLE;
         tx_idx_reg   <= 6'h00;
         o_tx_valid   <= 1'b0;
         o_tx_last    <= 1'b0;
      end else begin
         tx_state_reg <= tx_state_next;
         tx_idx_reg   <= tx_idx_next;
         o_tx_valid   <= tx_valid_next;
         o_tx_last    <= tx_last_next;
      end
   end

   assign o_tx_data = frm.data;

   // full duplex busy: frame start until the cable reports it sent
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         fd_busy_reg   <= 1'b0;
         wait_done_reg <= 1'b0;
      end else begin
         if (tx_start) begin
            fd_busy_reg   <= 1'b1;
            wait_done_reg <= 1'b0;
         end else if (tx_end) begin
            wait_done_reg <= 1'b1;
         end else if (wait_done_reg && i_tx_done) begin
            fd_busy_reg   <= 1'b0;
            wait_done_reg <= 1'b0;
         end
      end
   end

   // ---------------- half duplex back pressure ----------------
   logic bp_next;

   assign bp_next = !i_full_duplex && flow_en_reg &&
                    i_tx_enable && i_rx_congested;

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_back_pressure <= 1'b0;
      end else begin
         o_back_pressure <= bp_next;
      end
   end

   // busy view depends on the duplex mode
   assign busy = i_full_duplex ? fd_busy_reg
                               : o_back_pressure;

   // ---------------- pause frame receive decode ----------------
   logic [4:0]  rx_cnt_reg;
   logic [4:0]  rx_pos;
   logic        rx_match_reg;
   logic        rx_match_cur;
   logic [15:0] rx_ptime_reg;
   logic [7:0]  rx_expect;
   logic        rx_checked;
   logic        rx_byte_ok;
   logic        rx_end;
   logic        pause_ok;
   logic        filter_next;

   // position of the current byte within the frame
   assign rx_pos = i_rx_sof ? 5'h00 : rx_cnt_reg;

   // expected header bytes of a pause frame
   always_comb begin
      rx_expect  = 8'h00;
      rx_checked = 1'b1;
      if (rx_pos < 5'(SRC_ADDR_IDX)) begin
         rx_expect = PAUSE_DEST_ADDR[8'(47 - 8 * rx_pos) -: 8];
      end else if (rx_pos == 5'(TYPE_IDX)) begin
         rx_expect = CTRL_ETHERTYPE[15:8];
      end else if (rx_pos == 5'(TYPE_IDX) + 5'h01) begin
         rx_expect = CTRL_ETHERTYPE[7:0];
      end else if (rx_pos == 5'(OPCODE_IDX)) begin
         rx_expect = PAUSE_OPCODE[15:8];
      end else if (rx_pos == 5'(OPCODE_IDX) + 5'h01) begin
         rx_expect = PAUSE_OPCODE[7:0];
      end else begin
         rx_checked = 1'b0;
      end
   end

   assign rx_byte_ok   = !rx_checked || (i_rxd == rx_expect);
   assign rx_match_cur = (i_rx_sof ? 1'b1 : rx_match_reg) && rx_byte_ok;
   assign rx_end       = i_rx_valid && i_rx_eof;

   // whole frame decision; nothing is decoded while flow is off
   assign pause_ok = rx_end && flow_en_reg && i_rx_good &&
                     rx_match_cur && (rx_pos >= 5'(PAD_IDX));

   // filter status: filtering mode first, then pause frame option
   assign filter_next = i_filter_mode_active ? i_filter_pass
                      : pause_ok             ? pass_ctrl_reg
                      : i_filter_pass;

   // byte position, header match and captured pause time
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         rx_cnt_reg   <= 5'h00;
         rx_match_reg <= 1'b0;
         rx_ptime_reg <= 16'h0000;
      end else if (i_rx_valid) begin
         rx_match_reg <= rx_match_cur;
         if (rx_pos != 5'h1f) begin
            rx_cnt_reg <= rx_pos + 5'h01;
         end
         if (rx_pos == 5'(PTIME_IDX)) begin
            rx_ptime_reg[15:8] <= i_rxd;
         end
         if (rx_pos == 5'(PTIME_IDX) + 5'h01) begin
            rx_ptime_reg[7:0] <= i_rxd;
         end
      end
   end

   // every frame passes through to the application with its status
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_rxd             <= 8'h00;
         o_rx_valid        <= 1'b0;
         o_rx_sof          <= 1'b0;
         o_rx_eof          <= 1'b0;
         o_rx_status_valid <= 1'b0;
         o_rx_filter       <= 1'b0;
      end else begin
         o_rxd             <= i_rxd;
         o_rx_valid        <= i_rx_valid;
         o_rx_sof          <= i_rx_valid && i_rx_sof;
         o_rx_eof          <= rx_end;
         o_rx_status_valid <= rx_end;
         if (rx_end) begin
            o_rx_filter <= filter_next;
         end
      end
   end

   // ---------------- transmit pause timer ----------------
   logic [15:0]           quanta_reg;
   logic [SLOT_CNT_W-1:0] slot_cnt_reg;
   logic [SLOT_CNT_W-1:0] slot_load;
   logic                  pause_load;

   assign slot_load  = i_speed_100 ? SLOT_CNT_W'(SLOT_CYCLES_100M - 1)
                                   : SLOT_CYCLES_10 - SLOT_CNT_W'(1);
   assign pause_load = pause_ok && i_full_duplex;

   // counts pause quanta of one slot time each
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         quanta_reg   <= 16'h0000;
         slot_cnt_reg <= '0;
      end else if (!flow_en_reg) begin
         quanta_reg   <= 16'h0000;
         slot_cnt_reg <= '0;
      end else if (pause_load) begin
         quanta_reg   <= rx_ptime_reg;
         slot_cnt_reg <= slot_load;
      end else if (quanta_reg != 16'h0000) begin
         if (slot_cnt_reg == '0) begin
            quanta_reg   <= quanta_reg - 16'h0001;
            slot_cnt_reg <= slot_load;
         end else begin
            slot_cnt_reg <= slot_cnt_reg - SLOT_CNT_W'(1);
         end
      end
   end

   // transmitter stall while quanta remain
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_tx_pause <= 1'b0;
      end else begin
         o_tx_pause <= flow_en_reg && (quanta_reg != 16'h0000);
      end
   end

endmodule : mac_pause_flow_control

//--- design/pause_frame_rom.sv
// Purpose: produces the bytes of an outgoing pause control frame
// Assumes: index is stable around the clock edge, same clock as the core
// Notes:   output byte is registered; fcs is appended by the mac later
module pause_frame_rom
   import pause_fc_pkg::*;
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // frame byte port
   pause_frame_if.builder   frm
);

   logic [7:0] byte_next;
   logic [5:0] rel_idx;

   // byte offset inside the source address field
   assign rel_idx = frm.idx - SRC_ADDR_IDX;

   // field selection by byte index
   always_comb begin
      byte_next = 8'h00;
      if (frm.idx < SRC_ADDR_IDX) begin
         byte_next = PAUSE_DEST_ADDR[8'(47 - 8 * frm.idx) -: 8];
      end else if (frm.idx < TYPE_IDX) begin
         byte_next = frm.src_addr[8'(47 - 8 * rel_idx) -: 8];
      end else if (frm.idx == TYPE_IDX) begin
         byte_next = CTRL_ETHERTYPE[15:8];
      end else if (frm.idx == TYPE_IDX + 6'h01) begin
         byte_next = CTRL_ETHERTYPE[7:0];
      end else if (frm.idx == OPCODE_IDX) begin
         byte_next = PAUSE_OPCODE[15:8];
      end else if (frm.idx == OPCODE_IDX + 6'h01) begin
         byte_next = PAUSE_OPCODE[7:0];
      end else if (frm.idx == PTIME_IDX) begin
         byte_next = frm.pause_time[15:8];
      end else if (frm.idx == PTIME_IDX + 6'h01) begin
         byte_next = frm.pause_time[7:0];
      end
   end

   // registered byte out, zero pad past the pause time
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         frm.data <= 8'h00;
      end else begin
         frm.data <= byte_next;
      end
   end

endmodule : pause_frame_rom

//--- test/mac_pause_flow_control_chk.sv
// Purpose: port assertions for mac_pause_flow_control
// Assumes: one mac clock, active high reset
// Notes:   bound to the block at the foot of this file
module mac_pause_flow_control_chk
   import pause_fc_pkg::*;
(
   // clock, reset, register port, mode
   input wire logic        i_mclk,
   input wire logic        i_reset,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        i_full_duplex,
   input wire logic        i_tx_enable,
   // pause frame stream and flow outputs
   input wire logic [7:0]  o_tx_data,
   input wire logic        o_tx_valid,
   input wire logic        o_tx_last,
   input wire logic        i_tx_ready,
   input wire logic        o_tx_pause,
   input wire logic        o_back_pressure,
   // receive streams
   input wire logic [7:0]  i_rxd,
   input wire logic        i_rx_valid,
   input wire logic        i_rx_eof,
   input wire logic        i_rx_sof,
   input wire logic        i_filter_pass,
   input wire logic        i_filter_mode_active,
   input wire logic [7:0]  o_rxd,
   input wire logic        o_rx_valid,
   input wire logic        o_rx_eof,
   input wire logic        o_rx_sof,
   input wire logic        o_rx_status_valid,
   input wire logic        o_rx_filter
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   // last pause byte handed over
   sequence s_last_taken;
      o_tx_valid && o_tx_last && i_tx_ready;
   endsequence
   // end of a received frame
   sequence s_rx_end;
      i_rx_valid && i_rx_eof;
   endsequence

   a_rdata_idle: assert property (
      !i_reg_rd |=> o_reg_rdata == 32'h0)
      else $error("read data without a read");
   a_tx_off: assert property (
      !i_tx_enable && !o_tx_valid |=> !o_tx_valid)
      else $error("pause frame started with tx off");
   a_bp_off: assert property (
      !i_tx_enable || i_full_duplex |=> !o_back_pressure)
      else $error("back pressure out of half duplex");
   a_byte_hold: assert property (
      o_tx_valid && !i_tx_ready |=>
         o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
      else $error("pause byte changed while stalled");
   a_frame_head: assert property (
      $rose(o_tx_valid) |-> o_tx_data == PAUSE_DEST_ADDR[47:40])
      else $error("pause frame starts with wrong byte");
   a_frame_len: assert property (
      $rose(o_tx_valid) |-> ##[59:1000] s_last_taken)
      else $error("pause frame length wrong");
   a_frame_end: assert property (
      s_last_taken |=> !o_tx_valid)
      else $error("byte stream goes on after last");
   a_rx_copy: assert property (
      i_rx_valid |=> o_rx_valid && o_rxd == $past(i_rxd) &&
         o_rx_sof == $past(i_rx_sof))
      else $error("received byte not forwarded");
   a_status_eof: assert property (
      s_rx_end |=> o_rx_eof && o_rx_status_valid)
      else $error("no status at frame end");
   a_filter_mode: assert property (
      s_rx_end ##0 i_filter_mode_active |=>
         o_rx_filter == $past(i_filter_pass))
      else $error("filter mode not obeyed");
   a_pause_cause: assert property (
      $rose(o_tx_pause) |->
         $past(o_rx_status_valid) && $past(i_full_duplex, 2))
      else $error("pause without a received frame");
endmodule : mac_pause_flow_control_chk

bind mac_pause_flow_control mac_pause_flow_control_chk u_chk (
   .i_mclk, .i_reset, .i_reg_rd, .o_reg_rdata, .i_full_duplex,
   .i_tx_enable, .o_tx_data, .o_tx_valid, .o_tx_last, .i_tx_ready,
   .o_tx_pause, .o_back_pressure, .i_rxd, .i_rx_valid, .i_rx_eof,
   .i_filter_pass, .i_filter_mode_active, .o_rxd, .o_rx_valid,
   .o_rx_eof, .o_rx_status_valid, .o_rx_filter, .i_rx_sof, .o_rx_sof
);

//--- test/tb_mac_pause_flow_control.sv
// Purpose: self-checking bench for mac_pause_flow_control
// Assumes: 100 MHz clock, 16-cycle 10 Mb/s slot for short pauses
// Notes:   drivers queue expected results, a monitor compares them
module tb_mac_pause_flow_control
   import pause_fc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // design ports
   logic        i_mclk, i_reset, i_reg_wr, i_reg_rd, i_full_duplex;
   logic        i_speed_100, i_tx_enable, i_pause_req, i_rx_congested;
   logic        o_tx_valid, o_tx_last, i_tx_ready, i_tx_done, o_tx_pause;
   logic        o_back_pressure, i_rx_valid, i_rx_sof, i_rx_eof, i_rx_good;
   logic        i_filter_pass, i_filter_mode_active, o_rx_valid, o_rx_sof;
   logic        o_rx_eof, o_rx_status_valid, o_rx_filter;
   logic [7:0]  i_reg_addr, o_tx_data, i_rxd, o_rxd;
   logic [31:0] i_reg_wdata, o_reg_rdata;
   logic [47:0] i_station_addr;
   // bench state
   logic [31:0] exp_rd[$];
   logic [7:0]  exp_tx[$];
   logic        exp_flt[$];
   logic [15:0] pt;
   logic        rd_d, skip, slow;
   int          errors, total_checks, cyc;

   mac_pause_flow_control #(.SLOT_CYCLES_10(13'd16)) dut (
      .i_mclk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .i_full_duplex, .i_speed_100, .i_tx_enable,
      .i_station_addr, .i_pause_req, .i_rx_congested, .o_tx_data,
      .o_tx_valid, .o_tx_last, .i_tx_ready, .i_tx_done, .o_tx_pause,
      .o_back_pressure, .i_rxd, .i_rx_valid, .i_rx_sof, .i_rx_eof,
      .i_rx_good, .i_filter_pass, .i_filter_mode_active, .o_rxd,
      .o_rx_valid, .o_rx_sof, .o_rx_eof, .o_rx_status_valid, .o_rx_filter
   );
   tx_link_model link (
      .i_mclk, .i_reset, .i_slow(slow), .i_valid(o_tx_valid),
      .i_last(o_tx_last), .o_ready(i_tx_ready), .o_done(i_tx_done)
   );

   // clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // byte i of a pause frame
   function automatic logic [7:0] fb(int i, logic [47:0] sa,
                                     logic [15:0] t);
      logic [143:0] hdr;
      hdr = {PAUSE_DEST_ADDR, sa, CTRL_ETHERTYPE, PAUSE_OPCODE, t};
      return (i < 18) ? hdr[143 - 8 * i -: 8] : 8'h00;
   endfunction : fb

   task automatic cmp(logic [31:0] g, logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task automatic chk_rd;
      cmp(o_reg_rdata, exp_rd.size() ? exp_rd.pop_front() : 'x);
   endtask : chk_rd

   task automatic chk_tx;
      cmp(32'(o_tx_data), 32'(exp_tx.size() ? exp_tx.pop_front() : 8'hxx));
   endtask : chk_tx

   task automatic chk_flt;
      cmp(32'(o_rx_filter), 32'(exp_flt.size() ? exp_flt.pop_front() : 'x));
   endtask : chk_flt

   task automatic chk_lvl(logic g, logic e);
      cmp(32'(g), 32'(e));
   endtask : chk_lvl

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge i_mclk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_mclk);
      i_reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge i_mclk);
      exp_rd.push_back(e);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_mclk);
      i_reg_rd   <= 1'b0;
   endtask : rd

   task automatic req;
      @(posedge i_mclk);
      i_pause_req <= 1'b1;
      @(posedge i_mclk);
      i_pause_req <= 1'b0;
   endtask : req

   // read busy until clear, bounded
   task automatic poll;
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         skip = 1'b1;
         i_reg_addr <= FLOW_OFFSET;
         i_reg_rd   <= 1'b1;
         @(posedge i_mclk);
         i_reg_rd   <= 1'b0;
         @(negedge i_mclk);
         n++;
      end while (o_reg_rdata[BUSY_BIT] !== 1'b0 && n < 300);
      @(posedge i_mclk);
      skip = 1'b0;
      chk_lvl(n < 300, 1'b1);
   endtask : poll

   // one received frame, then filter status and pause length
   task automatic rxc(logic [15:0] ctl, logic pz, gd, md, fp, ef,
                      int ecyc);
      int n;
      n = 0;
      wr(FLOW_OFFSET, {pt, ctl});
      exp_flt.push_back(ef);
      for (int i = 0; i < 60; i++) begin
         @(posedge i_mclk);
         i_rx_valid           <= 1'b1;
         i_rx_sof             <= (i == 0);
         i_rx_eof             <= (i == 59);
         i_rxd                <= pz ? fb(i, 48'h0, 16'h0003) : 8'(i + 2);
         i_rx_good            <= gd;
         i_filter_pass        <= fp;
         i_filter_mode_active <= md;
      end
      @(posedge i_mclk);
      i_rx_valid <= 1'b0;
      i_rx_eof   <= 1'b0;
      repeat (ecyc + 8) begin
         @(negedge i_mclk);
         if (o_tx_pause === 1'b1)
            n++;
      end
      chk_lvl(n >= ecyc && n <= ecyc + 2, 1'b1);
   endtask : rxc

   task automatic wrap_up;
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   // compare each result with the oldest note
   always @(posedge i_mclk) rd_d <= i_reg_rd;
   always @(negedge i_mclk) begin
      if (rd_d === 1'b1 && !skip) chk_rd();
      if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) chk_tx();
      if (o_rx_status_valid === 1'b1) chk_flt();
   end

   // hang guard
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         errors++;
         wrap_up();
      end
   end

   // main sequence
   initial begin
      void'($urandom(81));
      {i_reg_wr, i_reg_rd, i_pause_req, i_rx_congested} = '0;
      {i_speed_100, i_rx_valid, i_rx_sof, i_rx_eof} = '0;
      {i_filter_pass, i_filter_mode_active, skip} = '0;
      {i_reg_addr, i_rxd, i_reg_wdata} = '0;
      {i_full_duplex, i_tx_enable, slow, i_reset, i_rx_good} = '1;
      pt = 16'($urandom);
      i_station_addr = {16'($urandom), $urandom};
      repeat (4) @(posedge i_mclk);
      i_reset <= 1'b0;
      rd(FLOW_OFFSET, FLOW_RESET);
      rd(8'h04, 32'h0);
      wr(FLOW_OFFSET, {pt, 16'h0001});
      wr(8'h0c, 32'hffff_ffff);
      rd(FLOW_OFFSET, {pt, 16'h0000});
      wr(FLOW_OFFSET, {pt, 16'h0006});
      for (int i = 0; i < 60; i++)
         exp_tx.push_back(fb(i, i_station_addr, pt));
      req();
      rd(FLOW_OFFSET, {pt, 16'h0007});
      req();
      poll();
      rd(FLOW_OFFSET, {pt, 16'h0006});
      i_tx_enable <= 1'b0;
      req();
      repeat (10) @(posedge i_mclk);
      // half duplex back pressure
      i_tx_enable    <= 1'b1;
      i_full_duplex  <= 1'b0;
      i_rx_congested <= 1'b1;
      repeat (3) @(negedge i_mclk);
      chk_lvl(o_back_pressure, 1'b1);
      rd(FLOW_OFFSET, {pt, 16'h0007});
      i_tx_enable <= 1'b0;
      repeat (3) @(negedge i_mclk);
      chk_lvl(o_back_pressure, 1'b0);
      rd(FLOW_OFFSET, {pt, 16'h0006});
      i_tx_enable    <= 1'b1;
      i_rx_congested <= 1'b0;
      poll();
      wr(FLOW_OFFSET, {pt, 16'h0004});
      i_rx_congested <= 1'b1;
      repeat (3) @(negedge i_mclk);
      chk_lvl(o_back_pressure, 1'b0);
      @(posedge i_mclk);
      i_rx_congested <= 1'b0;
      i_full_duplex  <= 1'b1;
      slow           <= 1'b0;
      // received frames in full duplex
      rxc(16'h0006, 1, 1, 0, 0, 1, 48);
      rxc(16'h0002, 1, 1, 0, 1, 0, 48);
      rxc(16'h0002, 1, 1, 1, 1, 1, 48);
      rxc(16'h0004, 1, 1, 0, 0, 0, 0);
      rxc(16'h0006, 1, 0, 0, 0, 0, 0);
      rxc(16'h0006, 0, 1, 0, 1, 1, 0);
      i_speed_100 <= 1'b1;
      rxc(16'h0006, 1, 1, 0, 0, 1, 3 * SLOT_CYCLES_100M);
      cmp(32'(exp_tx.size() + exp_flt.size()), 32'h0);
      wrap_up();
   end
endmodule : tb_mac_pause_flow_control

//--- test/tx_link_model.sv
// Purpose: transmitter taking pause frame bytes toward the cable
// Assumes: same clock as the block
// Notes:   random stalls when slow, done pulse after serialisation
module tx_link_model (
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_reset,
   // bench control and byte stream
   input  wire logic i_slow,
   input  wire logic i_valid,
   input  wire logic i_last,
   output logic      o_ready,
   output logic      o_done
);
   logic [3:0] wire_cnt;

   // take bytes, report the frame on the cable later
   always @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_ready  <= 1'b0;
         o_done   <= 1'b0;
         wire_cnt <= 4'h0;
      end else begin
         o_ready <= i_slow ? 1'($urandom) : 1'b1;
         o_done  <= (wire_cnt == 4'h1);
         if (i_valid && i_last && o_ready)
            wire_cnt <= 4'h9;  // serialisation delay
         else if (wire_cnt != 4'h0)
            wire_cnt <= wire_cnt - 4'h1;
      end
   end
endmodule : tx_link_model
